// >>> rtl/hvpp_pkg.sv
/*
  Constants for the parallel high-voltage programming port: command codes,
  action codes, event layout, reset values, sizes and programming times.
  Assumes a single 100 MHz clock and a synchronous active-high reset.
*/
`default_nettype none
package hvpp_pkg;
  // ************************************************************
  // sizes
  // ************************************************************
  localparam int DW             = 8;
  localparam int FLASH_AW       = 14;
  localparam int PAGE_WORD_BITS = 6;
  localparam int EE_AW          = 10;
  localparam int EE_PAGE_BITS   = 2;
  // ************************************************************
  // command and action codes
  // ************************************************************
  localparam logic [7:0] CMD_ERASE    = 8'h80;
  localparam logic [7:0] CMD_WR_FUSE  = 8'h40;
  localparam logic [7:0] CMD_WR_LOCK  = 8'h20;
  localparam logic [7:0] CMD_WR_FLASH = 8'h10;
  localparam logic [7:0] CMD_WR_EE    = 8'h11;
  localparam logic [7:0] CMD_RD_SIG   = 8'h08;
  localparam logic [7:0] CMD_RD_FUSE  = 8'h04;
  localparam logic [7:0] CMD_RD_FLASH = 8'h02;
  localparam logic [7:0] CMD_RD_EE    = 8'h03;
  localparam logic [7:0] CMD_NOOP     = 8'h00;
  localparam logic [1:0] XA_ADDR      = 2'h0;
  localparam logic [1:0] XA_DATA      = 2'h1;
  localparam logic [1:0] XA_CMD       = 2'h2;
  typedef enum logic [1:0] {EV_XTAL, EV_PAGE_LATCH_STROBE, EV_WR} hvpp_ev_t;
  // ************************************************************
  // event word layout: kind, action, selects, data
  // ************************************************************
  localparam int EVB_DATA = 0;
  localparam int EVB_BS1  = 8;
  localparam int EVB_BS2  = 9;
  localparam int EVB_XA   = 10;
  localparam int EVB_KIND = 12;
  localparam int EV_W     = 14;
  // ************************************************************
  // synchronised pin vector layout and its reset value
  // ************************************************************
  localparam int PIN_DATA  = 0;
  localparam int PIN_OE    = 8;
  localparam int PIN_WR    = 9;
  localparam int PIN_PAGE_LATCH_STROBE = 10;
  localparam int PIN_BS2   = 11;
  localparam int PIN_BS1   = 12;
  localparam int PIN_XA    = 13;
  localparam int PIN_XTAL  = 15;
  localparam int PIN_W     = 16;
  localparam logic [PIN_W-1:0] PIN_RST = 16'h0300;
  // ************************************************************
  // reset values, lock fields
  // ************************************************************
  localparam logic [7:0]  FUSE_LO_RST     = 8'hff;
  localparam logic [7:0]  FUSE_HI_RST     = 8'hff;
  localparam logic [7:0]  FUSE_EXT_RST    = 8'hff;
  localparam logic [7:0]  LOCK_RST        = 8'hff;
  localparam logic [7:0]  BOOT_LOCK_MASK  = 8'h3c;
  localparam logic [15:0] ERASED_WORD     = 16'hffff;
  localparam logic [7:0]  ERASED_BYTE     = 8'hff;
  localparam int          EESAVE_BIT      = 3;
  // ************************************************************
  // programming times
  // ************************************************************
  localparam int CLK_PERIOD_NS   = 10;
  localparam int T_WD_FLASH_NS   = 4500000;
  localparam int T_WD_EEPROM_NS  = 3600000;
  localparam int T_WD_ERASE_NS   = 9000000;
  localparam int FLASH_PROG_CYC  = (T_WD_FLASH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int EE_PROG_CYC     = (T_WD_EEPROM_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int ERASE_CYC       = (T_WD_ERASE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int FUSE_PROG_CYC   = 16;
  localparam int BUSY_W          = 20;
endpackage : hvpp_pkg
`default_nettype wire

// >>> rtl/hvpp_buf2.sv
/*
  Two-entry buffer with valid/ready on both sides.
  Assumes one clock and a synchronous active-high reset.
*/
`timescale 1ns/1ps
`default_nettype none
module hvpp_buf2 #(
  parameter int W = 8
) (
  input  wire logic         clk,
  input  wire logic         rst,
  input  wire logic         in_valid,
  output logic              in_ready,
  input  wire logic [W-1:0] in_data,
  output logic              out_valid,
  input  wire logic         out_ready,
  output logic      [W-1:0] out_data
);
  logic [W-1:0] mem_ff [2];
  logic         wp_ff;
  logic         rp_ff;
  logic [1:0]   cnt_ff;
  logic         push;
  logic         pop;

  assign in_ready  = (cnt_ff != 2'h2);
  assign out_valid = (cnt_ff != 2'h0);
  assign out_data  = mem_ff[rp_ff];
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;

  always_ff @(posedge clk) begin
    if (push) begin
      mem_ff[wp_ff] <= in_data;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      wp_ff  <= 1'b0;
      rp_ff  <= 1'b0;
      cnt_ff <= 2'h0;
    end else begin
      if (push) begin
        wp_ff <= ~wp_ff;
      end
      if (pop) begin
        rp_ff <= ~rp_ff;
      end
      cnt_ff <= cnt_ff + {1'b0, push} - {1'b0, pop};
    end
  end
endmodule : hvpp_buf2
`default_nettype wire

// >>> rtl/hvpp_port.sv
/*
  Command interpreter of the parallel high-voltage programming port:
  loads command, address and data, page-programs flash and eeprom, writes
  fuses and lock bits and returns memory, fuse, lock and signature bytes.
  Assumes the programmer pins are asynchronous to clk; the outside world
  resolves the data bus from data_out and data_oe_n.
*/
`timescale 1ns/1ps
`default_nettype none
module hvpp_port
  import hvpp_pkg::*;
#(
  parameter int          FLASH_CYC = hvpp_pkg::FLASH_PROG_CYC,
  parameter int          EE_CYC    = hvpp_pkg::EE_PROG_CYC,
  parameter int          ERASE_CNT = hvpp_pkg::ERASE_CYC,
  parameter logic [7:0]  SIG0      = 8'ha7,  // arbitrary value
  parameter logic [7:0]  SIG1      = 8'h55,  // arbitrary value
  parameter logic [7:0]  SIG2      = 8'h0a,  // arbitrary value
  parameter logic [7:0]  CAL_BYTE  = 8'h80   // arbitrary value
) (
  input  wire logic                    clk,
  input  wire logic                    rst,
  input  wire logic                    crystal_strobe_in,
  input  wire logic                    action_select_hi,
  input  wire logic                    action_select_lo,
  input  wire logic                    byte_select_first,
  input  wire logic                    byte_select_second,
  input  wire logic                    page_latch_strobe,
  input  wire logic                    write_strobe_n,
  input  wire logic                    output_enable_n,
  input  wire logic [hvpp_pkg::DW-1:0] data_in,
  output logic      [hvpp_pkg::DW-1:0] data_out,
  output logic                         data_oe_n,
  output logic                         ready_busy_flag,
  output logic                         load_ready
);
  import hvpp_pkg::*;

  typedef enum logic {ST_READY, ST_BUSY} hvpp_st_t;

  localparam int FLASH_WORDS = 1 << FLASH_AW;
  localparam int PAGE_WORDS  = 1 << PAGE_WORD_BITS;
  localparam int EE_BYTES    = 1 << EE_AW;
  localparam int EE_PAGE     = 1 << EE_PAGE_BITS;

  // ************************************************************
  // pin synchroniser and edge detect
  // ************************************************************
  logic [PIN_W-1:0] pin_s1_ff;
  logic [PIN_W-1:0] pin_s2_ff;
  logic [PIN_W-1:0] pin_s3_ff;
  logic             xtal_rise;
  logic             page_latch_strobe_rise;
  logic             wr_fall;

  always_ff @(posedge clk) begin
    if (rst) begin
      pin_s1_ff <= PIN_RST;
      pin_s2_ff <= PIN_RST;
      pin_s3_ff <= PIN_RST;
    end else begin
      pin_s1_ff <= {crystal_strobe_in, action_select_hi, action_select_lo,
                    byte_select_first, byte_select_second, page_latch_strobe,
                    write_strobe_n, output_enable_n, data_in};
      pin_s2_ff <= pin_s1_ff;
      pin_s3_ff <= pin_s2_ff;
    end
  end

  assign xtal_rise  = pin_s2_ff[PIN_XTAL] && !pin_s3_ff[PIN_XTAL];
  assign page_latch_strobe_rise = pin_s2_ff[PIN_PAGE_LATCH_STROBE] && !pin_s3_ff[PIN_PAGE_LATCH_STROBE];
  assign wr_fall    = !pin_s2_ff[PIN_WR] && pin_s3_ff[PIN_WR];

  // ************************************************************
  // event buffer: holds strobes while a program cycle runs
  // ************************************************************
  hvpp_ev_t          ev_kind_in;
  logic [EV_W-1:0]   ev_in;
  logic              ev_in_valid;
  logic              ev_valid;
  logic              ev_ready;
  logic [EV_W-1:0]   ev;
  logic              ev_fire;
  hvpp_st_t          st_ff;

  always_comb begin
    if (xtal_rise) begin
      ev_kind_in = EV_XTAL;
    end else if (page_latch_strobe_rise) begin
      ev_kind_in = EV_PAGE_LATCH_STROBE;
    end else begin
      ev_kind_in = EV_WR;
    end
  end

  assign ev_in_valid = xtal_rise || page_latch_strobe_rise || wr_fall;
  assign ev_in       = {ev_kind_in, pin_s2_ff[PIN_XA+1:PIN_XA], pin_s2_ff[PIN_BS2],
                        pin_s2_ff[PIN_BS1], pin_s2_ff[PIN_DATA+DW-1:PIN_DATA]};
  assign ev_ready    = (st_ff == ST_READY);
  assign ev_fire     = ev_valid && ev_ready;

  hvpp_buf2 #(
    .W(EV_W)
  ) u_evbuf (
    .clk      (clk),
    .rst      (rst),
    .in_valid (ev_in_valid),
    .in_ready (load_ready),
    .in_data  (ev_in),
    .out_valid(ev_valid),
    .out_ready(ev_ready),
    .out_data (ev)
  );

  hvpp_ev_t     ev_kind;
  logic [1:0]   ev_xa;
  logic         ev_bs1;
  logic         ev_bs2;
  logic [7:0]   ev_data;
  logic         ld_cmd;
  logic         ld_addr;
  logic         ld_data;
  logic         ev_latch;
  logic         ev_write;

  assign ev_kind  = hvpp_ev_t'(ev[EVB_KIND+1:EVB_KIND]);
  assign ev_xa    = ev[EVB_XA+1:EVB_XA];
  assign ev_bs1   = ev[EVB_BS1];
  assign ev_bs2   = ev[EVB_BS2];
  assign ev_data  = ev[EVB_DATA+DW-1:EVB_DATA];
  assign ld_cmd   = ev_fire && ev_kind == EV_XTAL && ev_xa == XA_CMD && !ev_bs1;
  assign ld_addr  = ev_fire && ev_kind == EV_XTAL && ev_xa == XA_ADDR;
  assign ld_data  = ev_fire && ev_kind == EV_XTAL && ev_xa == XA_DATA;
  assign ev_latch = ev_fire && ev_kind == EV_PAGE_LATCH_STROBE;
  assign ev_write = ev_fire && ev_kind == EV_WR;

  // ************************************************************
  // command, address and data registers
  // ************************************************************
  logic [7:0] cmd_ff;
  logic [7:0] addr_lo_ff;
  logic [7:0] addr_hi_ff;
  logic [7:0] dlo_ff;
  logic [7:0] dhi_ff;

  always_ff @(posedge clk) begin
    if (rst) begin
      cmd_ff     <= CMD_NOOP;
      addr_lo_ff <= 8'h00;
      addr_hi_ff <= 8'h00;
      dlo_ff     <= 8'hff;
      dhi_ff     <= 8'hff;
    end else begin
      if (ld_cmd) begin
        cmd_ff <= ev_data;
      end
      if (ld_addr && !ev_bs1) begin
        addr_lo_ff <= ev_data;
      end
      if (ld_addr && ev_bs1) begin
        addr_hi_ff <= ev_data;
      end
      if (ld_data && !ev_bs1) begin
        dlo_ff <= ev_data;
      end
      if (ld_data && ev_bs1) begin
        dhi_ff <= ev_data;
      end
    end
  end

  logic [FLASH_AW-1:0]                flash_addr;
  logic [FLASH_AW-PAGE_WORD_BITS-1:0] flash_page;
  logic [EE_AW-1:0]                   ee_addr;
  logic [EE_AW-EE_PAGE_BITS-1:0]      ee_page;

  assign flash_addr = {addr_hi_ff[FLASH_AW-9:0], addr_lo_ff};
  assign flash_page = flash_addr[FLASH_AW-1:PAGE_WORD_BITS];
  assign ee_addr    = {addr_hi_ff[EE_AW-9:0], addr_lo_ff};
  assign ee_page    = ee_addr[EE_AW-1:EE_PAGE_BITS];

  // ************************************************************
  // page buffers and write session
  // ************************************************************
  logic [15:0] fpbuf_ff [PAGE_WORDS];
  logic [7:0]  epbuf_ff [EE_PAGE];
  logic        wr_session_ff;
  logic        noop_ld;

  assign noop_ld = ld_cmd && ev_data == CMD_NOOP;

  always_ff @(posedge clk) begin
    if (rst || noop_ld) begin
      wr_session_ff <= 1'b0;
      for (int i = 0; i < PAGE_WORDS; i++) begin
        fpbuf_ff[i] <= ERASED_WORD;
      end
      for (int i = 0; i < EE_PAGE; i++) begin
        epbuf_ff[i] <= ERASED_BYTE;
      end
    end else if (ev_latch) begin
      if (cmd_ff == CMD_WR_FLASH && ev_bs1) begin
        fpbuf_ff[flash_addr[PAGE_WORD_BITS-1:0]] <= {dhi_ff, dlo_ff};
        wr_session_ff <= 1'b1;
      end
      if (cmd_ff == CMD_WR_EE) begin
        epbuf_ff[ee_addr[EE_PAGE_BITS-1:0]] <= dlo_ff;
        wr_session_ff <= 1'b1;
      end
    end
  end

  // ************************************************************
  // nonvolatile arrays
  // ************************************************************
  logic [15:0] flash_mem_ff [FLASH_WORDS];
  logic [7:0]  ee_mem_ff    [EE_BYTES];
  logic [7:0]  fuse_lo_ff;
  logic [7:0]  fuse_hi_ff;
  logic [7:0]  fuse_ext_ff;
  logic [7:0]  lock_ff;
  logic        do_flash;
  logic        do_ee;
  logic        do_erase;
  logic        do_fuse;
  logic        do_lock;
  logic        mode3;

  assign do_flash = ev_write && cmd_ff == CMD_WR_FLASH;
  assign do_ee    = ev_write && cmd_ff == CMD_WR_EE && !ev_bs1;
  assign do_erase = ev_write && cmd_ff == CMD_ERASE;
  assign do_fuse  = ev_write && cmd_ff == CMD_WR_FUSE;
  assign do_lock  = ev_write && cmd_ff == CMD_WR_LOCK;
  assign mode3    = lock_ff[1:0] == 2'h0;

  always_ff @(posedge clk) begin
    if (do_erase) begin
      for (int i = 0; i < FLASH_WORDS; i++) begin
        flash_mem_ff[i] <= ERASED_WORD;
      end
    end else if (do_flash) begin
      for (int i = 0; i < PAGE_WORDS; i++) begin
        flash_mem_ff[{flash_page, PAGE_WORD_BITS'(i)}] <= fpbuf_ff[i];
      end
    end
  end

  always_ff @(posedge clk) begin
    if (do_erase && fuse_hi_ff[EESAVE_BIT]) begin
      for (int i = 0; i < EE_BYTES; i++) begin
        ee_mem_ff[i] <= ERASED_BYTE;
      end
    end else if (do_ee) begin
      for (int i = 0; i < EE_PAGE; i++) begin
        ee_mem_ff[{ee_page, EE_PAGE_BITS'(i)}] <= epbuf_ff[i];
      end
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      fuse_lo_ff  <= FUSE_LO_RST;
      fuse_hi_ff  <= FUSE_HI_RST;
      fuse_ext_ff <= FUSE_EXT_RST;
    end else if (do_fuse) begin
      unique case ({ev_bs2, ev_bs1})
        2'b00: fuse_lo_ff <= dlo_ff;
        2'b01: fuse_hi_ff <= dlo_ff;
        2'b10: fuse_ext_ff <= dlo_ff;
        2'b11: ;
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (rst || do_erase) begin
      lock_ff <= LOCK_RST;
    end else if (do_lock) begin
      // writes can only clear bits; mode 3 freezes the boot lock field
      lock_ff <= lock_ff & (dlo_ff | (mode3 ? BOOT_LOCK_MASK : 8'h00));
    end
  end

  // ************************************************************
  // busy timer
  // ************************************************************
  logic [BUSY_W-1:0] busy_cnt_ff;

  always_ff @(posedge clk) begin
    if (rst) begin
      st_ff       <= ST_READY;
      busy_cnt_ff <= '0;
    end else begin
      unique case (st_ff)
        ST_READY: begin
          if (do_flash || do_ee || do_erase || do_fuse || do_lock) begin
            st_ff <= ST_BUSY;
            if (do_flash) begin
              busy_cnt_ff <= BUSY_W'(FLASH_CYC - 1);
            end else if (do_ee) begin
              busy_cnt_ff <= BUSY_W'(EE_CYC - 1);
            end else if (do_erase) begin
              busy_cnt_ff <= BUSY_W'(ERASE_CNT - 1);
            end else begin
              busy_cnt_ff <= BUSY_W'(FUSE_PROG_CYC - 1);
            end
          end
        end
        ST_BUSY: begin
          if (busy_cnt_ff == '0) begin
            st_ff <= ST_READY;
          end else begin
            busy_cnt_ff <= busy_cnt_ff - 1'b1;
          end
        end
      endcase
    end
  end

  assign ready_busy_flag = (st_ff == ST_READY);

  // ************************************************************
  // read path
  // ************************************************************
  logic [7:0]  nxt_dout;
  logic [15:0] rd_word;
  logic [7:0]  data_out_ff;
  logic        data_oe_n_ff;
  logic        rd_bs1;
  logic        rd_bs2;

  assign rd_word = flash_mem_ff[flash_addr];
  assign rd_bs1  = pin_s2_ff[PIN_BS1];
  assign rd_bs2  = pin_s2_ff[PIN_BS2];

  always_comb begin
    nxt_dout = 8'hff;
    unique case (cmd_ff)
      CMD_RD_FLASH: nxt_dout = rd_bs1 ? rd_word[15:8] : rd_word[7:0];
      CMD_RD_EE: begin
        if (!rd_bs1) begin
          nxt_dout = ee_mem_ff[ee_addr];
        end
      end
      CMD_RD_FUSE: begin
        unique case ({rd_bs2, rd_bs1})
          2'b00: nxt_dout = fuse_lo_ff;
          2'b11: nxt_dout = fuse_hi_ff;
          2'b10: nxt_dout = fuse_ext_ff;
          2'b01: nxt_dout = lock_ff;
        endcase
      end
      CMD_RD_SIG: begin
        if (!rd_bs1) begin
          unique case (addr_lo_ff)
            8'h00: nxt_dout = SIG0;
            8'h01: nxt_dout = SIG1;
            8'h02: nxt_dout = SIG2;
            default: nxt_dout = 8'hff;
          endcase
        end else if (addr_lo_ff == 8'h00) begin
          nxt_dout = CAL_BYTE;
        end
      end
      default: nxt_dout = 8'hff;
    endcase
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      data_out_ff  <= 8'hff;
      data_oe_n_ff <= 1'b1;
    end else begin
      data_out_ff  <= nxt_dout;
      data_oe_n_ff <= pin_s2_ff[PIN_OE];
    end
  end

  assign data_out  = data_out_ff;
  assign data_oe_n = data_oe_n_ff;

  // ************************************************************
  // assertions
  // ************************************************************
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  sequence s_flash_start;
    ev_write && cmd_ff == CMD_WR_FLASH && ready_busy_flag;
  endsequence
  sequence s_oe_low;
    !output_enable_n [*3];
  endsequence

  AST_CMD_LOAD: assert property (ld_cmd |=> cmd_ff == $past(ev_data))
    else $error("command not loaded");
  AST_ADDR_HI: assert property (ld_addr && ev_bs1 |=> addr_hi_ff == $past(ev_data)
    && $stable(addr_lo_ff))
    else $error("high address load wrong");
  AST_DATA_LO: assert property (ld_data && !ev_bs1 |=> dlo_ff == $past(ev_data)
    && $stable(dhi_ff))
    else $error("low data load wrong");
  AST_FLASH_BUSY: assert property (s_flash_start |=> !ready_busy_flag [*2])
    else $error("flash program did not go busy");
  AST_NOOP: assert property (noop_ld |=> !wr_session_ff && cmd_ff == CMD_NOOP)
    else $error("noop did not end session");
  AST_DRIVE: assert property (s_oe_low |-> ##3 !data_oe_n)
    else $error("bus not driven under output enable");
  AST_RELEASE: assert property (output_enable_n [*4] |-> data_oe_n)
    else $error("bus driven without output enable");
  AST_LOCK_UP: assert property ((lock_ff & ~$past(lock_ff)) != 8'h00 |-> $past(do_erase))
    else $error("lock bit unprogrammed without erase");
  AST_BOOT_LOCK: assert property (mode3 && do_lock
    |=> (lock_ff & BOOT_LOCK_MASK) == ($past(lock_ff) & BOOT_LOCK_MASK))
    else $error("boot lock changed in mode 3");
  AST_ONE_LOAD: assert property (xtal_rise |=> !xtal_rise)
    else $error("double load from one pulse");
  AST_BUSY_BLOCKS: assert property (!ready_busy_flag
    |=> $stable(cmd_ff) && $stable(addr_lo_ff) && $stable(addr_hi_ff))
    else $error("event taken while busy");
endmodule : hvpp_port
`default_nettype wire

// >>> verif/hvpp_prog.sv
/*
  Model of the external programmer: drives the port pins after the falling edge.
  Assumes the bench resolves the shared data bus from the device's enable.
*/
`timescale 1ns/1ps
`default_nettype none
module hvpp_prog (
  input  wire logic       clk,
  input  wire logic       rdy,
  output logic            xt,
  output logic      [1:0] xa,
  output logic            bs1,
  output logic            bs2,
  output logic            pl,
  output logic            wr_n,
  output logic            oe_n,
  output logic      [7:0] d,
  output logic            look
);
  initial begin
    {xt, xa, bs1, bs2, pl, wr_n, oe_n, d, look} = 17'h0c600;
  end
  task automatic gap();
    repeat (4) @(negedge clk);
  endtask : gap
  task automatic ld(input logic [1:0] a, input logic s, input logic [7:0] v);
    xa = a;
    bs1 = s;
    d = v;
    gap();
    xt = 1'b1;
    gap();
    xt = 1'b0;
    gap();
  endtask : ld
  task automatic latch();
    bs1 = 1'b1;
    gap();
    pl = 1'b1;
    gap();
    pl = 1'b0;
    gap();
  endtask : latch
  task automatic wr(input logic s1, input logic s2);
    bs1 = s1;
    bs2 = s2;
    gap();
    wr_n = 1'b0;
    gap();
    wr_n = 1'b1;
    repeat (2) @(negedge clk);
  endtask : wr
  task automatic wt();
    for (int k = 0; k < 40 && rdy !== 1'b1; k++) @(negedge clk);
  endtask : wt
  task automatic rd(input logic s1, input logic s2);
    bs1 = s1;
    bs2 = s2;
    oe_n = 1'b0;
    gap();
    look = 1'b1;
    @(negedge clk);
    look = 1'b0;
    oe_n = 1'b1;
    gap();
  endtask : rd
endmodule : hvpp_prog
`default_nettype wire

// >>> verif/hvpp_port_test.sv
/*
  Self-checking bench of the programming port.
  Assumes the programmer model above; bus is driven by whoever's enable is low.
*/
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin n_tests++; if ((a) !== (b)) begin errors++; \
  $display("mismatch t=%0t got=%h exp=%h", $time, a, b); end end
module hvpp_port_test;
  import hvpp_pkg::*;
  logic       clk, rst, xt, bs1, bs2, pl, wr_n, oe_n, look, dev_oe_n, busy, load_ready;
  logic [1:0] xa;
  logic [7:0] d, din, dout, e;
  logic [7:0] r [4];
  logic [7:0] q [$];
  int         errors, n_tests, seed;
  assign din = dev_oe_n ? d : dout;
  hvpp_port #(.FLASH_CYC(8), .EE_CYC(6), .ERASE_CNT(10), .SIG0(8'ha7), .SIG1(8'h55),
    .SIG2(8'h0a), .CAL_BYTE(8'h80)) i_hvpp_port (.clk(clk), .rst(rst),
    .crystal_strobe_in(xt), .action_select_hi(xa[1]), .action_select_lo(xa[0]),
    .byte_select_first(bs1), .byte_select_second(bs2), .page_latch_strobe(pl),
    .write_strobe_n(wr_n), .output_enable_n(oe_n), .data_in(din), .data_out(dout),
    .data_oe_n(dev_oe_n), .ready_busy_flag(busy), .load_ready(load_ready));
  hvpp_prog i_hvpp_prog (.clk(clk), .rdy(busy), .xt(xt), .xa(xa), .bs1(bs1), .bs2(bs2),
    .pl(pl), .wr_n(wr_n), .oe_n(oe_n), .d(d), .look(look));
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  always @(posedge clk) if (look === 1'b1) begin
    e = q.pop_front();
    `CHK(dev_oe_n, 1'b0)
    `CHK(dout, e)
  end
  task automatic rd(input logic s1, input logic s2, input logic [7:0] x);
    q.push_back(x);
    i_hvpp_prog.rd(s1, s2);
  endtask : rd
  task automatic wp(input logic s1, input logic s2);
    i_hvpp_prog.wr(s1, s2);
    `CHK(busy, 1'b0)
    i_hvpp_prog.wt();
    `CHK(busy, 1'b1)
  endtask : wp
  task automatic results();
    $display("errors=%0d comparisons=%0d", errors, n_tests);
    if (errors == 0 && n_tests > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : results
  initial begin
    repeat (20000) @(posedge clk);
    errors++;
    results();
  end
  // ************************************************************
  // main sequence
  // ************************************************************
  initial begin
    rst = 1'b1;
    seed = 91;
    for (int i = 0; i < 4; i++) r[i] = 8'($random(seed));
    repeat (2) @(negedge clk);
    rst = 1'b0;
    `CHK(load_ready, 1'b1)
    i_hvpp_prog.ld(2'h2, 1'b0, CMD_WR_FLASH);
    i_hvpp_prog.ld(2'h0, 1'b0, 8'h45);
    i_hvpp_prog.ld(2'h1, 1'b0, r[0]);
    i_hvpp_prog.ld(2'h1, 1'b1, r[1]);
    i_hvpp_prog.latch();
    i_hvpp_prog.ld(2'h0, 1'b1, 8'h02);
    wp(1'b0, 1'b0);
    i_hvpp_prog.ld(2'h2, 1'b0, CMD_NOOP);
    i_hvpp_prog.ld(2'h2, 1'b0, CMD_RD_FLASH);
    rd(1'b0, 1'b0, r[0]);
    rd(1'b1, 1'b0, r[1]);
    i_hvpp_prog.ld(2'h0, 1'b0, 8'h46);
    rd(1'b0, 1'b0, 8'hff);
    i_hvpp_prog.ld(2'h2, 1'b0, CMD_WR_EE);
    i_hvpp_prog.ld(2'h0, 1'b1, 8'h01);
    i_hvpp_prog.ld(2'h0, 1'b0, 8'h07);
    i_hvpp_prog.ld(2'h1, 1'b0, r[2]);
    i_hvpp_prog.latch();
    wp(1'b0, 1'b0);
    i_hvpp_prog.ld(2'h2, 1'b0, CMD_RD_EE);
    rd(1'b0, 1'b0, r[2]);
    i_hvpp_prog.ld(2'h2, 1'b0, CMD_WR_FUSE);
    for (int i = 0; i < 3; i++) begin
      i_hvpp_prog.ld(2'h1, 1'b0, r[3] + 8'(i));
      wp(i == 1, i == 2);
    end
    i_hvpp_prog.ld(2'h2, 1'b0, CMD_WR_LOCK);
    i_hvpp_prog.ld(2'h1, 1'b0, 8'hfc);
    wp(1'b0, 1'b0);
    i_hvpp_prog.ld(2'h1, 1'b0, 8'hc3);
    wp(1'b0, 1'b0);
    i_hvpp_prog.ld(2'h2, 1'b0, CMD_RD_FUSE);
    rd(1'b0, 1'b0, r[3]);
    rd(1'b1, 1'b1, r[3] + 8'h01);
    rd(1'b0, 1'b1, r[3] + 8'h02);
    rd(1'b1, 1'b0, 8'hfc);
    i_hvpp_prog.ld(2'h2, 1'b0, CMD_RD_SIG);
    for (int i = 0; i < 3; i++) begin
      i_hvpp_prog.ld(2'h0, 1'b0, 8'(i));
      rd(1'b0, 1'b0, i == 0 ? 8'ha7 : i == 1 ? 8'h55 : 8'h0a);
    end
    i_hvpp_prog.ld(2'h0, 1'b0, 8'h00);
    rd(1'b1, 1'b0, 8'h80);
    i_hvpp_prog.ld(2'h2, 1'b0, CMD_ERASE);
    wp(1'b0, 1'b0);
    i_hvpp_prog.ld(2'h2, 1'b0, CMD_RD_FUSE);
    i_hvpp_prog.ld(2'h2, 1'b1, CMD_RD_SIG);
    rd(1'b1, 1'b0, 8'hff);
    `CHK(dev_oe_n, 1'b1)
    results();
  end
endmodule : hvpp_port_test
`default_nettype wire
